// ===== uadp_top.sv
// UART transceiver with shared data register, status flags and APB slave.
`timescale 1ns/10ps
`default_nettype none
module uadp_top
	import uadp_pkg::*;
(
	// System
	input  wire logic        CLK_SYS,
	input  wire logic        RST_N,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Serial pins
	output logic             TX_OUT,
	output logic             TX_OE,
	output logic             TX_PULL_EN,
	input  wire logic        RX_IN,
	output logic             RX_PULL_EN,
	input  wire logic        IO_PULL_TX,
	input  wire logic        IO_PULL_RX,
	// Power and interrupt
	input  wire logic        POWER_DOWN,
	output logic             WAKE_REQ,
	output logic             UART_IRQ
);

	uadp_ctrl1_s    ctrl1_q;
	uadp_ctrl2_s    ctrl2_q;
	logic [7:0]     baud_q;
	uadp_status_s   st;
	uadp_status_s   st_rd;
	logic           parity_error_flag_q, nf_q, framing_error_flag_q, overrun_flag_q, receive_available_flag_q, transmit_buffer_empty_flag_q, transmitter_idle_flag_q, receiver_idle_flag_q;
	logic           err_arm_q, receive_available_flag_arm_q, transmit_buffer_empty_flag_arm_q;
	logic           tx_en, rx_en, tx_kill, rx_kill, baud_tick;
	logic           setup, acc, hit, data_rd, data_wr, stat_rd;
	logic [7:0]     rd_byte;
	uadp_tx_state_e tx_state_q;
	logic [8:0]     tx_hold_q;
	logic           hold_full_q;
	logic [12:0]    tx_frame;
	logic [12:0]    tx_sr_q;
	logic [3:0]     tx_left_q, tx_os_q, tx_brk_cnt_q, tx_pidx;
	logic           tx_par, tx_bit, tx_load;
	uadp_rx_state_e rx_state_q;
	logic           rx_meta_q, rx_sync_q, rx_prev_q;
	logic [3:0]     rx_os_q, rx_idx_q, rx_stop_idx, rx_pidx;
	logic [11:0]    rx_bits_q;
	logic [2:0]     rx_smp_q;
	logic           rx_noise_q, rx_push_q, rx_maj, rx_noisy;
	uadp_rx_entry_s rx_entry;
	uadp_rx_entry_s fifo_q [2];
	uadp_rx_entry_s head;
	logic           wr_ptr_q, rd_ptr_q, push_ok, pop, head_last;
	logic [1:0]     cnt_q, cnt_next;

	assign tx_en   = ctrl1_q.on && ctrl2_q.tx_on;
	assign rx_en   = ctrl1_q.on && ctrl2_q.rx_on;
	assign tx_kill = !tx_en;
	assign rx_kill = !rx_en;

	uadp_baud u_baud (
		.clk        (CLK_SYS),
		.rst_n      (RST_N),
		.run        (ctrl1_q.on && (ctrl2_q.tx_on || ctrl2_q.rx_on)),
		.high_speed (ctrl2_q.high_speed),
		.divisor    (baud_q),
		.tick       (baud_tick)
	);

	// APB: no wait states; PREADY comes in the first access cycle and read data is captured into a flop in the setup cycle.
	assign setup   = PSEL && !PENABLE;
	assign acc     = PSEL && PENABLE && PREADY;
	assign data_rd = acc && !PWRITE && (PADDR == UADP_OFS_DATA);
	assign data_wr = acc && PWRITE && (PADDR == UADP_OFS_DATA);
	assign stat_rd = acc && !PWRITE && (PADDR == UADP_OFS_STATUS);

	assign st = '{parity_error_flag: parity_error_flag_q, nf: nf_q, framing_error_flag: framing_error_flag_q, overrun_flag: overrun_flag_q, receiver_idle_flag: receiver_idle_flag_q,
		receive_available_flag: receive_available_flag_q, transmitter_idle_flag: transmitter_idle_flag_q, transmit_buffer_empty_flag: transmit_buffer_empty_flag_q};
	assign st_rd = uadp_status_s'(PRDATA[7:0]);
	assign head  = fifo_q[rd_ptr_q];

	always_comb begin
		hit     = 1'b1;
		rd_byte = 8'h00;
		if (PADDR == UADP_OFS_STATUS) begin
			rd_byte = st;
		end else if (PADDR == UADP_OFS_CTRL1) begin
			// An empty buffer holds no ninth bit, so none is shown.
			rd_byte = {ctrl1_q[7:2], (cnt_q != 2'h0) && head.ninth, 1'b0};
		end else if (PADDR == UADP_OFS_CTRL2) begin
			rd_byte = ctrl2_q;
		end else if (PADDR == UADP_OFS_DATA) begin
			rd_byte = head.data;
		end else if (PADDR == UADP_OFS_BAUD) begin
			rd_byte = baud_q;
		end else begin
			hit = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h00000000;
		end else begin
			PREADY  <= setup;
			PSLVERR <= setup && !hit;
			if (setup) begin
				PRDATA <= {24'h000000, rd_byte};
			end
		end
	end

	// Control registers; status is never written.
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			ctrl1_q <= UADP_CTRL1_RST;
			ctrl2_q <= UADP_CTRL2_RST;
			baud_q  <= UADP_BAUD_RST;
		end else begin
			if (acc && PWRITE && PADDR == UADP_OFS_CTRL1) begin
				ctrl1_q     <= PWDATA[7:0];
				ctrl1_q.rx8 <= 1'b0;
			end
			if (acc && PWRITE && PADDR == UADP_OFS_CTRL2) begin
				ctrl2_q <= PWDATA[7:0];
			end
			if (acc && PWRITE && PADDR == UADP_OFS_BAUD) begin
				baud_q <= PWDATA[7:0];
			end
			if (!ctrl1_q.on) begin
				ctrl2_q.tx_on <= 1'b0;
				ctrl2_q.rx_on <= 1'b0;
				ctrl1_q.brk   <= 1'b0;
			end
		end
	end

	// Status read arms the clearing sequence; the next data access completes it.
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N || !ctrl1_q.on) begin
			err_arm_q  <= 1'b0;
			receive_available_flag_arm_q <= 1'b0;
			transmit_buffer_empty_flag_arm_q <= 1'b0;
		end else if (stat_rd) begin
			err_arm_q  <= 1'b1;
			receive_available_flag_arm_q <= st_rd.receive_available_flag;
			transmit_buffer_empty_flag_arm_q <= st_rd.transmit_buffer_empty_flag;
		end else if (data_rd || data_wr) begin
			err_arm_q  <= 1'b0;
			receive_available_flag_arm_q <= 1'b0;
			transmit_buffer_empty_flag_arm_q <= 1'b0;
		end
	end

	// Transmit frame: start, data, optional ninth bit, optional parity, stop bits.
	always_comb begin
		tx_frame      = 13'h1FFF;
		tx_frame[0]   = 1'b0;
		tx_frame[8:1] = tx_hold_q[7:0];
		tx_par        = (^tx_hold_q[7:0]) ^ (ctrl1_q.nine && tx_hold_q[8]) ^ ctrl1_q.par_odd;
		tx_pidx       = UADP_STOP_IDX + {3'h0, ctrl1_q.nine};
		if (ctrl1_q.nine) begin
			tx_frame[9] = tx_hold_q[8];
		end
		if (ctrl1_q.par_on) begin
			tx_frame[tx_pidx] = tx_par;
		end
	end

	assign tx_bit  = baud_tick && (tx_os_q == UADP_OS_LAST);
	assign tx_load = (tx_state_q == TX_IDLE) && hold_full_q;

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N || tx_kill) begin
			tx_state_q   <= TX_IDLE;
			tx_hold_q    <= 9'h000;
			hold_full_q  <= 1'b0;
			tx_sr_q      <= 13'h1FFF;
			tx_left_q    <= 4'h0;
			tx_os_q      <= 4'h0;
			tx_brk_cnt_q <= 4'h0;
			TX_OUT       <= 1'b1;
		end else begin
			if (tx_state_q != TX_IDLE && baud_tick) begin
				tx_os_q <= tx_os_q + 4'h1;
			end
			case (tx_state_q)
				TX_IDLE: begin
					tx_os_q <= 4'h0;
					if (hold_full_q) begin
						tx_state_q  <= TX_SHIFT;
						TX_OUT      <= tx_frame[0];
						tx_sr_q     <= {1'b1, tx_frame[12:1]};
						tx_left_q   <= tx_pidx + {3'h0, ctrl1_q.par_on} + {3'h0, ctrl1_q.two_stop};
						hold_full_q <= 1'b0;
					end else if (ctrl1_q.brk) begin
						tx_state_q   <= TX_BREAK;
						TX_OUT       <= 1'b0;
						tx_brk_cnt_q <= 4'h0;
					end
				end
				TX_SHIFT: begin
					if (tx_bit) begin
						if (tx_left_q == 4'h0) begin
							tx_state_q <= TX_IDLE;
						end else begin
							TX_OUT    <= tx_sr_q[0];
							tx_sr_q   <= {1'b1, tx_sr_q[12:1]};
							tx_left_q <= tx_left_q - 4'h1;
						end
					end
				end
				TX_BREAK: begin
					if (tx_brk_cnt_q == UADP_BREAK_BITS && !ctrl1_q.brk) begin
						tx_state_q <= TX_IDLE;
						TX_OUT     <= 1'b1;
					end else if (tx_bit && tx_brk_cnt_q != UADP_BREAK_BITS) begin
						tx_brk_cnt_q <= tx_brk_cnt_q + 4'h1;
					end
				end
				default: begin
					tx_state_q <= TX_IDLE;
				end
			endcase
			if (data_wr) begin
				tx_hold_q   <= {ctrl1_q.tx8, PWDATA[7:0]};
				hold_full_q <= 1'b1;
			end
		end
	end

	// Transmit flags; a load in the clearing cycle keeps the flag set.
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N || tx_kill) begin
			transmit_buffer_empty_flag_q  <= 1'b1;
			transmitter_idle_flag_q <= 1'b1;
		end else begin
			if (transmit_buffer_empty_flag_arm_q && data_wr) begin
				transmit_buffer_empty_flag_q <= 1'b0;
			end
			if (tx_load) begin
				transmit_buffer_empty_flag_q <= 1'b1;
			end
			transmitter_idle_flag_q <= transmit_buffer_empty_flag_q && !hold_full_q && (tx_state_q == TX_IDLE) && !ctrl1_q.brk
				&& !data_wr;
		end
	end

	// Receive pin synchroniser and mid-bit majority vote.
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			rx_meta_q <= 1'b1;
			rx_sync_q <= 1'b1;
			rx_prev_q <= 1'b1;
		end else begin
			rx_meta_q <= RX_IN;
			rx_sync_q <= rx_meta_q;
			rx_prev_q <= rx_sync_q;
		end
	end

	assign rx_maj   = (rx_smp_q[0] && rx_smp_q[1]) || (rx_smp_q[0] && rx_smp_q[2])
		|| (rx_smp_q[1] && rx_smp_q[2]);
	assign rx_noisy = (rx_smp_q != 3'h0) && (rx_smp_q != 3'h7);
	assign rx_pidx     = UADP_STOP_IDX + {3'h0, ctrl1_q.nine};
	assign rx_stop_idx = rx_pidx + {3'h0, ctrl1_q.par_on};

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N || rx_kill) begin
			rx_state_q <= RX_IDLE;
			receiver_idle_flag_q    <= 1'b1;
			rx_os_q    <= 4'h0;
			rx_idx_q   <= 4'h0;
			rx_smp_q   <= 3'h7;
			rx_noise_q <= 1'b0;
			rx_push_q  <= 1'b0;
			rx_bits_q  <= 12'hFFF;
		end else begin
			rx_push_q <= 1'b0;
			case (rx_state_q)
				RX_IDLE: begin
					if (!rx_sync_q) begin
						rx_state_q <= RX_FRAME;
						receiver_idle_flag_q    <= 1'b0;
						rx_os_q    <= 4'h0;
						rx_idx_q   <= 4'h0;
						rx_noise_q <= 1'b0;
					end
				end
				RX_FRAME: begin
					if (baud_tick) begin
						rx_os_q <= rx_os_q + 4'h1;
						if (rx_os_q >= UADP_SMP_FIRST && rx_os_q <= UADP_SMP_LAST) begin
							rx_smp_q <= {rx_smp_q[1:0], rx_sync_q};
						end
						if (rx_os_q == UADP_OS_LAST) begin
							if (rx_idx_q == 4'h0 && rx_maj) begin
								rx_state_q <= RX_IDLE; // A glitch, not a start bit.
								receiver_idle_flag_q    <= 1'b1;
							end else begin
								rx_bits_q[rx_idx_q] <= rx_maj;
								rx_noise_q <= rx_noise_q || rx_noisy;
								rx_idx_q   <= rx_idx_q + 4'h1;
								if (rx_idx_q == rx_stop_idx) begin
									rx_state_q <= RX_IDLE;
									receiver_idle_flag_q    <= 1'b1;
									rx_push_q  <= 1'b1;
								end
							end
						end
					end
				end
				default: begin
					rx_state_q <= RX_IDLE;
				end
			endcase
		end
	end

	// Completed character with its error bits, valid while rx_push_q is high.
	always_comb begin
		rx_entry       = '0;
		rx_entry.data  = rx_bits_q[8:1];
		rx_entry.ninth = ctrl1_q.nine && rx_bits_q[9];
		rx_entry.parity_error_flag  = ctrl1_q.par_on && ((^rx_bits_q[8:1]) ^ rx_entry.ninth
			^ rx_bits_q[rx_pidx] ^ ctrl1_q.par_odd);
		rx_entry.framing_error_flag  = !rx_bits_q[rx_stop_idx];
		rx_entry.nf    = rx_noise_q;
	end

	// Two-entry receive FIFO; an overrun blocks transfers until it is cleared.
	assign push_ok  = rx_push_q && (cnt_q != UADP_FIFO_DEPTH) && !overrun_flag_q;
	assign pop      = data_rd && (cnt_q != 2'h0);
	assign cnt_next = cnt_q + {1'b0, push_ok} - {1'b0, pop};

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N || rx_kill) begin
			cnt_q    <= 2'h0;
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
		end else begin
			cnt_q <= cnt_next;
			if (push_ok) begin
				wr_ptr_q <= !wr_ptr_q;
			end
			if (pop) begin
				rd_ptr_q <= !rd_ptr_q;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (push_ok) begin
			fifo_q[wr_ptr_q] <= rx_entry;
		end
	end

	// Receive flags: a new event in the clearing cycle wins over the clear.
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N || !ctrl1_q.on) begin
			parity_error_flag_q <= 1'b0;
			nf_q   <= 1'b0;
			framing_error_flag_q <= 1'b0;
			overrun_flag_q <= 1'b0;
			receive_available_flag_q <= 1'b0;
		end else begin
			if (err_arm_q && (data_rd || data_wr)) begin
				parity_error_flag_q <= 1'b0;
				nf_q   <= 1'b0;
				framing_error_flag_q <= 1'b0;
				overrun_flag_q <= 1'b0;
			end
			if (rx_kill || (receive_available_flag_arm_q && data_rd && cnt_next == 2'h0)) begin
				receive_available_flag_q <= 1'b0;
			end
			if (push_ok) begin
				receive_available_flag_q <= 1'b1;
				if (rx_entry.parity_error_flag) begin
					parity_error_flag_q <= 1'b1;
				end
				if (rx_entry.nf) begin
					nf_q <= 1'b1;
				end
				if (rx_entry.framing_error_flag) begin
					framing_error_flag_q <= 1'b1;
				end
			end
			if (rx_push_q && cnt_q == UADP_FIFO_DEPTH) begin
				overrun_flag_q <= 1'b1;
			end
		end
	end

	assign head_last = ctrl1_q.nine ? head.ninth : head.data[7];

	// Pins, wake-up and the shared interrupt.
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			TX_OE      <= 1'b0;
			TX_PULL_EN <= 1'b0;
			RX_PULL_EN <= 1'b0;
			WAKE_REQ   <= 1'b0;
			UART_IRQ   <= 1'b0;
		end else begin
			TX_OE      <= tx_en;
			TX_PULL_EN <= !tx_en && IO_PULL_TX;
			RX_PULL_EN <= !rx_en && IO_PULL_RX;
			WAKE_REQ   <= POWER_DOWN && ctrl2_q.wake_on && rx_prev_q && !rx_sync_q;
			UART_IRQ   <= (ctrl2_q.receive_interrupt_on && (receive_available_flag_q || overrun_flag_q))
				|| (ctrl2_q.addr_on && receive_available_flag_q && head_last)
				|| (ctrl2_q.tx_empty_interrupt_on && transmit_buffer_empty_flag_q)
				|| (ctrl2_q.tx_idle_interrupt_on && transmitter_idle_flag_q);
		end
	end

endmodule
`default_nettype wire

// ===== uadp_pkg.sv
// Package with the register map, field layouts, reset values and timing of the UART block.
`default_nettype none
package uadp_pkg;

	// APB byte offsets of the registers.
	localparam logic [7:0] UADP_OFS_STATUS = 8'h00;
	localparam logic [7:0] UADP_OFS_CTRL1  = 8'h04;
	localparam logic [7:0] UADP_OFS_CTRL2  = 8'h08;
	localparam logic [7:0] UADP_OFS_DATA   = 8'h0C;
	localparam logic [7:0] UADP_OFS_BAUD   = 8'h10;

	// Reset values.
	localparam logic [7:0] UADP_STATUS_RST = 8'h0B;
	localparam logic [7:0] UADP_CTRL1_RST  = 8'h00;
	localparam logic [7:0] UADP_CTRL2_RST  = 8'h00;
	localparam logic [7:0] UADP_BAUD_RST   = 8'h00;

	// Bit timing: sixteen baud ticks per bit, three samples around mid-bit.
	localparam logic [3:0] UADP_OS_LAST     = 4'hF;
	localparam logic [3:0] UADP_SMP_FIRST   = 4'h7;
	localparam logic [3:0] UADP_SMP_LAST    = 4'h9;
	localparam logic [1:0] UADP_LOW_SPD_PAD = 2'h3;
	localparam logic [3:0] UADP_BREAK_BITS  = 4'hD;

	// Frame layout: index of the first stop bit for eight data bits, no parity.
	localparam logic [3:0] UADP_STOP_IDX   = 4'h9;
	localparam logic [1:0] UADP_FIFO_DEPTH = 2'h2;

	typedef struct packed {
		logic parity_error_flag;
		logic nf;
		logic framing_error_flag;
		logic overrun_flag;
		logic receiver_idle_flag;
		logic receive_available_flag;
		logic transmitter_idle_flag;
		logic transmit_buffer_empty_flag;
	} uadp_status_s;

	typedef struct packed {
		logic on;
		logic nine;
		logic par_on;
		logic par_odd;
		logic two_stop;
		logic brk;
		logic rx8;
		logic tx8;
	} uadp_ctrl1_s;

	typedef struct packed {
		logic tx_on;
		logic rx_on;
		logic high_speed;
		logic addr_on;
		logic wake_on;
		logic receive_interrupt_on;
		logic tx_idle_interrupt_on;
		logic tx_empty_interrupt_on;
	} uadp_ctrl2_s;

	typedef struct packed {
		logic       nf;
		logic       framing_error_flag;
		logic       parity_error_flag;
		logic       ninth;
		logic [7:0] data;
	} uadp_rx_entry_s;

	typedef enum logic [2:0] {
		TX_IDLE  = 3'h1,
		TX_SHIFT = 3'h2,
		TX_BREAK = 3'h4
	} uadp_tx_state_e;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'h1,
		RX_FRAME = 2'h2
	} uadp_rx_state_e;

endpackage
`default_nettype wire

// ===== uadp_baud.sv
// Baud rate generator producing the sixteen-times oversampling tick.
`timescale 1ns/10ps
`default_nettype none
module uadp_baud
	import uadp_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Control
	input  wire logic       run,
	input  wire logic       high_speed,
	input  wire logic [7:0] divisor,
	// Tick
	output logic            tick
);

	logic [9:0] cnt_q;
	logic [9:0] limit;

	// Low speed divides four times further than high speed.
	always_comb begin
		if (high_speed) begin
			limit = {2'h0, divisor};
		end else begin
			limit = {divisor, UADP_LOW_SPD_PAD};
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !run) begin
			cnt_q <= 10'h000;
			tick  <= 1'b0;
		end else if (cnt_q >= limit) begin
			cnt_q <= 10'h000;
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 10'h001;
			tick  <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ===== uadp_monitor.sv
// Concurrent checks on the ports of the UART top module.
`timescale 1ns/10ps
`default_nettype none
module uadp_monitor
	import uadp_pkg::*;
(
	// System
	input wire logic        CLK_SYS,
	input wire logic        RST_N,
	// APB
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	// Pins
	input wire logic        TX_OUT,
	input wire logic        TX_OE,
	input wire logic        TX_PULL_EN,
	input wire logic        IO_PULL_TX,
	input wire logic        WAKE_REQ
);
	logic mapped;
	assign mapped = PADDR inside {UADP_OFS_STATUS, UADP_OFS_CTRL1, UADP_OFS_CTRL2,
		UADP_OFS_DATA, UADP_OFS_BAUD};
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	sequence setup_s;
		PSEL && !PENABLE;
	endsequence
	sequence answer_s;
		PSEL && PENABLE && PREADY;
	endsequence
	a_ready_after_setup: assert property (setup_s |=> answer_s)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (PREADY |=> !PREADY)
		else $error("ready longer than one cycle");
	a_error_unmapped: assert property (setup_s ##0 !mapped |=> PSLVERR)
		else $error("no error for unmapped address");
	a_error_mapped: assert property (PSLVERR |-> !$past(mapped))
		else $error("error for mapped address");
	a_upper_zero: assert property (PREADY |-> PRDATA[31:8] == 24'h000000)
		else $error("upper read data not zero");
	a_rdata_holds: assert property (!(PSEL && !PENABLE) |=> $stable(PRDATA))
		else $error("read data moved without setup");
	a_pull_off_tx: assert property (TX_OE |-> !TX_PULL_EN)
		else $error("pull-high on driven transmit pin");
	a_pull_follow: assert property (!TX_OE && $past(RST_N) && $past(RST_N, 2)
		|-> TX_PULL_EN == $past(IO_PULL_TX)) else $error("pull-high not from io control");
	a_wake_pulse: assert property (WAKE_REQ |=> !WAKE_REQ)
		else $error("wake request longer than a pulse");
	a_bit_stands: assert property (TX_OE && $changed(TX_OUT) |=> $stable(TX_OUT)[*8])
		else $error("serial bit shorter than eight clocks");
endmodule
bind uadp_top uadp_monitor i_mon (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL),
	.PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.TX_OUT(TX_OUT), .TX_OE(TX_OE), .TX_PULL_EN(TX_PULL_EN), .IO_PULL_TX(IO_PULL_TX),
	.WAKE_REQ(WAKE_REQ));
`default_nettype wire

// ===== uadp_serial_dev.sv
// Behavioural serial device on the far side of the UART pins.
`timescale 1ns/10ps
`default_nettype none
module uadp_serial_dev
	import uadp_pkg::*;
(
	// Line and format
	input  wire logic        clk,
	input  wire logic        tx_line,
	input  wire uadp_ctrl1_s cfg,
	input  wire logic [15:0] bit_clks,
	output logic             rx_line
);
	logic [11:0] got_q[$];
	logic [11:0] sh;
	initial rx_line = 1'b1;
	function automatic int nb();
		return 9 + cfg.nine + cfg.par_on + cfg.two_stop;
	endfunction
	// Faults: bit 0 wrong parity, bit 1 low stop bit, bit 2 glitch in the first data bit.
	function automatic logic [11:0] frame(input logic [8:0] v, input logic [2:0] flt);
		logic [11:0] f;
		int          k;
		f = 12'hFFF;
		f[7:0] = v[7:0];
		k = 8;
		if (cfg.nine) begin
			f[8] = v[8];
			k = 9;
		end
		if (cfg.par_on) begin
			f[k] = ^v[7:0] ^ (cfg.nine & v[8]) ^ cfg.par_odd ^ flt[0];
			k++;
		end
		f[k] = !flt[1];
		return f;
	endfunction
	task automatic send(input logic [8:0] v, input logic [2:0] flt);
		logic [11:0] f;
		f = frame(v, flt);
		rx_line <= 1'b0;
		repeat (bit_clks) @(posedge clk);
		for (int i = 0; i < nb(); i++) begin
			rx_line <= f[i];
			repeat (bit_clks / 2) @(posedge clk);
			rx_line <= f[i] ^ (flt[2] && i == 0);
			repeat (2) @(posedge clk);
			rx_line <= f[i];
			repeat (bit_clks / 2 - 2) @(posedge clk);
		end
		rx_line <= 1'b1;
	endtask
	// Samples every bit after the start bit at its middle and keeps them all: data, ninth, parity and stop bits.
	always begin
		@(negedge tx_line);
		sh = 12'hFFF;
		repeat (bit_clks / 2) @(posedge clk);
		for (int i = 0; i < nb(); i++) begin
			repeat (bit_clks) @(posedge clk);
			sh[i] = tx_line;
		end
		got_q.push_back(sh);
	end
endmodule
`default_nettype wire

// ===== uadp_top_tb_top.sv
// Self-checking testbench for the UART block with an APB master and a serial partner.
`timescale 1ns/10ps
`default_nettype none
module uadp_top_tb_top
	import uadp_pkg::*;
;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        tx_out;
	logic        tx_oe;
	logic        tx_pull;
	logic        rx_pull;
	logic        rx_line;
	logic        pull_tx;
	logic        pull_rx;
	logic        pwr_down = 1'b0;
	logic        wake;
	logic        irq;
	uadp_ctrl1_s c1 = 8'h00;
	integer      seed = 32'h3C34D55D;
	int          miscompares = 0;
	int          compares = 0;
	int          wakes = 0;
	int          n;
	logic [8:0]  rq;
	logic [7:0]  exp_q[$];
	logic [7:0]  txq[$];
	logic        ovr = 1'b0;
	logic [7:0]  fmt[5] = '{8'h80, 8'hC1, 8'hA0, 8'hB0, 8'h88};
	logic [3:0]  et[3] = '{4'h8, 4'h2, 4'h4};
	uadp_top i_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .TX_OUT(tx_out), .TX_OE(tx_oe), .TX_PULL_EN(tx_pull),
		.RX_IN(rx_line), .RX_PULL_EN(rx_pull), .IO_PULL_TX(pull_tx), .IO_PULL_RX(pull_rx),
		.POWER_DOWN(pwr_down), .WAKE_REQ(wake), .UART_IRQ(irq));
	uadp_serial_dev i_dev (.clk(clk_sys), .tx_line(tx_out), .cfg(c1), .bit_clks(16'h0020),
		.rx_line(rx_line));
	initial forever #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) wakes <= wakes + int'(wake === 1'b1);
	initial begin
		repeat (60000) @(posedge clk_sys);
		miscompares++;
		finish_test();
	end
	task automatic finish_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t %s: %0h not %0h", $time, m, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, v};
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rq = {pslverr, prdata[7:0]};
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [8:0] e, input string m);
		apb(1'b0, a, 8'h00);
		chk(rq, e, m);
	endtask
	// Expected status: error nibble {parity, noise, framing, overrun} and {idle, empty} of the sender.
	function automatic logic [8:0] st(input logic [3:0] e, input logic [1:0] t);
		return {1'b0, e[3:1], e[0] | ovr, 1'b1, exp_q.size() != 0, t};
	endfunction
	task automatic rx(input logic [7:0] v, input logic [2:0] flt);
		i_dev.send({1'b0, v}, flt);
		if (exp_q.size() < 2 && !ovr) exp_q.push_back(v);
		else ovr = 1'b1;
		repeat (8) @(posedge clk_sys);
	endtask
	task automatic rdata(input string m);
		logic [7:0] e;
		e = exp_q.pop_front();
		rd(UADP_OFS_DATA, {1'b0, e}, m);
		ovr = 1'b0;
	endtask
	initial begin
		{pull_tx, pull_rx} <= 2'($random(seed));
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(UADP_OFS_STATUS, 9'h00B, "status reset");
		rd(UADP_OFS_CTRL1, 9'h000, "ctrl1 reset");
		rd(UADP_OFS_CTRL2, 9'h000, "ctrl2 reset");
		rd(UADP_OFS_BAUD, 9'h000, "baud reset");
		apb(1'b1, UADP_OFS_STATUS, 8'hFF);
		rd(UADP_OFS_STATUS, 9'h00B, "status write ignored");
		rd(8'h14, 9'h100, "unmapped");
		$display("test reset done");
		apb(1'b1, UADP_OFS_BAUD, 8'h01);
		c1 = 8'h80;
		apb(1'b1, UADP_OFS_CTRL1, c1);
		apb(1'b1, UADP_OFS_CTRL2, 8'hE0);
		repeat (2) @(posedge clk_sys);
		chk({tx_oe, tx_pull, rx_pull}, 3'h4, "pins on");
		rd(UADP_OFS_STATUS, 9'h00B, "empty on enable");
		foreach (fmt[i]) begin
			c1 = fmt[i];
			apb(1'b1, UADP_OFS_CTRL1, c1);
			for (int j = 0; j < 2; j++) begin
				txq.push_back(8'($random(seed)));
				apb(1'b1, UADP_OFS_DATA, txq[j]);
				rd(UADP_OFS_STATUS, j ? 9'h008 : 9'h009, "sender busy");
			end
			for (n = 0; n < 2000 && i_dev.got_q.size() < 2; n++) @(posedge clk_sys);
			repeat (2) chk(i_dev.got_q.pop_front(), i_dev.frame({c1.tx8, txq.pop_front()},
				3'h0), "tx frame");
			repeat (64) @(posedge clk_sys);
			rd(UADP_OFS_STATUS, 9'h00B, "sender idle");
		end
		$display("test transmit done");
		c1 = 8'h84;
		apb(1'b1, UADP_OFS_CTRL1, c1);
		repeat (640) @(posedge clk_sys);
		chk(tx_out, 1'b0, "break held");
		c1 = 8'h80;
		apb(1'b1, UADP_OFS_CTRL1, c1);
		// Leave the line high for a full bit before the next break.
		repeat (40) @(posedge clk_sys);
		c1 = 8'h84;
		apb(1'b1, UADP_OFS_CTRL1, c1);
		c1 = 8'h80;
		apb(1'b1, UADP_OFS_CTRL1, c1);
		for (n = 0; n < 2000 && tx_out !== 1'b1; n++) @(posedge clk_sys);
		chk(n >= UADP_BREAK_BITS * 32 - 40 && n < 2000, 1'b1, "break length");
		repeat (400) @(posedge clk_sys);
		i_dev.got_q.delete();
		$display("test break done");
		repeat (3) rx(8'($random(seed)), 3'h0);
		rd(UADP_OFS_STATUS, st(4'h0, 2'h3), "overrun");
		rdata("fifo head");
		rd(UADP_OFS_STATUS, st(4'h0, 2'h3), "one left");
		rdata("fifo tail");
		rd(UADP_OFS_STATUS, st(4'h0, 2'h3), "fifo empty");
		c1 = 8'hA0;
		apb(1'b1, UADP_OFS_CTRL1, c1);
		foreach (et[i]) begin
			rx(8'($random(seed)), 3'(1 << i));
			rd(UADP_OFS_STATUS, st(et[i], 2'h3), "error flag");
			rdata("error char");
			rd(UADP_OFS_STATUS, st(4'h0, 2'h3), "error cleared");
		end
		$display("test receive done");
		c1 = 8'h80;
		apb(1'b1, UADP_OFS_CTRL1, c1);
		apb(1'b1, UADP_OFS_CTRL2, 8'hEC);
		pwr_down <= 1'b1;
		n = wakes;
		rx(8'hFF, 3'h0);
		chk(wakes - n, 1, "wake pulse");
		chk(irq, 1'b1, "irq on data");
		pwr_down <= 1'b0;
		rd(UADP_OFS_STATUS, st(4'h0, 2'h3), "irq status");
		rdata("irq data");
		repeat (2) @(posedge clk_sys);
		chk(irq, 1'b0, "irq cleared");
		apb(1'b1, UADP_OFS_CTRL2, 8'h00);
		repeat (2) @(posedge clk_sys);
		chk({tx_oe, tx_pull, rx_pull}, {1'b0, pull_tx, pull_rx}, "pins off");
		$display("test irq wake pins done");
		finish_test();
	end
endmodule
`default_nettype wire
